// File: design/ddl_defs.svh
// Constants shared by both ends of the dual serial DAC input link.
`ifndef DDL_DEFS_SVH
`define DDL_DEFS_SVH

`define DDL_WORD_BITS  18
`define DDL_LAST_BIT   17
`define DDL_CLK_HZ     50000000
`define DDL_BCLK_HZ    13500000
`define DDL_HALF_CYC   ((`DDL_CLK_HZ + 2 * `DDL_BCLK_HZ - 1) / (2 * `DDL_BCLK_HZ))
`define DDL_SEL_BITS   2
`define DDL_FIFO_W     (`DDL_SEL_BITS + 2 * `DDL_WORD_BITS)
`define DDL_FIFO_DEPTH 8
`define DDL_LATCH_IDLE 2'h3

`endif

// File: design/ddl_pkg.sv
// Types and small helper functions of the dual serial DAC input link.
`include "ddl_defs.svh"

package ddl_pkg;

  typedef logic [`DDL_WORD_BITS-1:0] ddl_word_type;

  typedef enum logic [2:0] {
    DDL_IDLE     = 3'b000,
    DDL_SHIFT_LO = 3'b001,
    DDL_SHIFT_HI = 3'b010,
    DDL_LATCH    = 3'b011,
    DDL_GAP      = 3'b100
  } ddl_ctl_state_type;

  function automatic logic ddl_rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic logic ddl_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

endpackage

// File: design/ddl_link_if.sv
// Serial link between the word controller and the dual DAC input latch.
`timescale 1ns/1ns

interface ddl_link_if;
  logic bit_clk;
  logic left_serial_in;
  logic right_serial_in;
  logic left_latch_n;
  logic right_latch_n;

  modport ctl (
    output bit_clk,
    output left_serial_in,
    output right_serial_in,
    output left_latch_n,
    output right_latch_n
  );

  modport dev (
    input bit_clk,
    input left_serial_in,
    input right_serial_in,
    input left_latch_n,
    input right_latch_n
  );
endinterface

// File: design/ddl_dev.sv
// Device end: two serial input registers and two converter word latches.
//
// Operation
// RL1: Words are 18-bit twos complement, MSB first.
// RL2: Separate serial inputs for left and right.
// RL3: Latch falling edge copies last 18 bits.
// RL4: One shared bit clock shifts both registers.
// RL5: Data sampled on bit clock rising edge.
// RL6: Bit clock up to 13.5 MHz supported.
// RL7: Both latches may share one word clock.
// RL8: Shift all bits, then pulse target latch.
// RL9: All latches low together load same word.
// RL10: Converter word holds between latch edges.
`timescale 1ns/1ns

`include "ddl_defs.svh"

module ddl_dev
  import ddl_pkg::*;
(
  input  wire logic   I_CLK,
  input  wire logic   I_RESETN,
  ddl_link_if.dev     LINK,
  output ddl_word_type O_LEFT_WORD,
  output ddl_word_type O_RIGHT_WORD,
  output logic        O_LEFT_UPDATE,
  output logic        O_RIGHT_UPDATE
);

  logic [1:0] ser_in;
  logic [1:0] latch_n;
  logic       bclk_prev_q;
  logic       bclk_prev_d;
  logic       bclk_rise;

  assign ser_in  = {LINK.right_serial_in, LINK.left_serial_in}; // [RL2]
  assign latch_n = {LINK.right_latch_n, LINK.left_latch_n};

  always_comb begin
    bclk_prev_d = LINK.bit_clk;
    bclk_rise   = ddl_rose(bclk_prev_q, LINK.bit_clk); // [RL5] [RL6]
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_prev_d;
    end
  end

  // Each channel has its own register pair but both follow the single bit clock edge.
  for (genvar ch = 0; ch < 2; ch++) begin : ch_g
    ddl_word_type shift_q;
    ddl_word_type shift_d;
    ddl_word_type hold_q;
    ddl_word_type hold_d;
    logic         latch_prev_q;
    logic         latch_prev_d;
    logic         upd_q;
    logic         upd_d;
    logic         load;

    always_comb begin
      load         = ddl_fell(latch_prev_q, latch_n[ch]);
      latch_prev_d = latch_n[ch];
      shift_d      = shift_q;
      hold_d       = hold_q; // [RL10]
      if (bclk_rise) begin
        shift_d = {shift_q[`DDL_WORD_BITS-2:0], ser_in[ch]}; // [RL1] [RL4] [RL5]
      end
      if (load) begin
        hold_d = shift_q; // [RL3]
      end
      upd_d = load;
    end

    always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
        shift_q      <= '0;
        hold_q       <= '0;
        latch_prev_q <= 1'b1;
        upd_q        <= 1'b0;
      end else begin
        shift_q      <= shift_d;
        hold_q       <= hold_d;
        latch_prev_q <= latch_prev_d;
        upd_q        <= upd_d;
      end
    end
  end

  assign O_LEFT_WORD    = ch_g[0].hold_q;
  assign O_RIGHT_WORD   = ch_g[1].hold_q;
  assign O_LEFT_UPDATE  = ch_g[0].upd_q;
  assign O_RIGHT_UPDATE = ch_g[1].upd_q;

endmodule

// File: design/ddl_ctl.sv
// Controller end: word FIFO, serialiser, bit clock divider and latch pulses.
`timescale 1ns/1ns

`include "ddl_defs.svh"

module ddl_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  always_comb begin
    empty      = (wr_q == rd_q);
    full       = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    o_wr_ready = ~full;
    o_rd_valid = ~empty;
    o_rd_data  = mem_q[rd_q[AW-1:0]];
    push       = i_wr_valid & ~full;
    pop        = i_rd_ready & ~empty;
    wr_d       = push ? wr_q + 1'b1 : wr_q;
    rd_d       = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_wr_data;
    end
  end

endmodule

module ddl_ctl
  import ddl_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  ddl_word_type    I_LEFT_WORD,
  input  ddl_word_type    I_RIGHT_WORD,
  input  wire logic [1:0] I_LATCH_SEL,
  input  wire logic       I_VALID,
  output logic            O_READY,
  output logic            O_BUSY,
  ddl_link_if.ctl         LINK
);

  localparam logic [1:0] HALF_LAST = 2'(`DDL_HALF_CYC - 1);
  localparam logic [4:0] LAST_BIT  = 5'(`DDL_LAST_BIT);

  logic [`DDL_FIFO_W-1:0] f_data;
  logic                   f_valid;
  logic                   f_ready;
  ddl_ctl_state_type      state_q;
  ddl_ctl_state_type      state_d;
  logic [1:0]             div_q;
  logic [1:0]             div_d;
  logic [4:0]             bit_q;
  logic [4:0]             bit_d;
  ddl_word_type           lsh_q;
  ddl_word_type           lsh_d;
  ddl_word_type           rsh_q;
  ddl_word_type           rsh_d;
  logic [1:0]             sel_q;
  logic [1:0]             sel_d;
  logic                   bclk_q;
  logic                   bclk_d;
  logic [1:0]             latch_n_q;
  logic [1:0]             latch_n_d;
  logic                   tick;

  ddl_fifo #(
    .WIDTH (`DDL_FIFO_W),
    .DEPTH (`DDL_FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (I_CLK),
    .i_resetn   (I_RESETN),
    .i_wr_data  ({I_LATCH_SEL, I_LEFT_WORD, I_RIGHT_WORD}),
    .i_wr_valid (I_VALID),
    .o_wr_ready (O_READY),
    .o_rd_data  (f_data),
    .o_rd_valid (f_valid),
    .i_rd_ready (f_ready)
  );

  always_comb begin
    f_ready   = (state_q == DDL_IDLE);
    tick      = (div_q == HALF_LAST); // [RL6]
    state_d   = state_q;
    div_d     = tick ? 2'h0 : 2'(div_q + 2'h1);
    bit_d     = bit_q;
    lsh_d     = lsh_q;
    rsh_d     = rsh_q;
    sel_d     = sel_q;
    bclk_d    = bclk_q;
    latch_n_d = latch_n_q;
    case (state_q)
      DDL_IDLE: begin
        div_d = 2'h0;
        if (f_valid) begin
          sel_d   = f_data[`DDL_FIFO_W-1 -: `DDL_SEL_BITS];
          lsh_d   = f_data[2*`DDL_WORD_BITS-1 -: `DDL_WORD_BITS];
          rsh_d   = f_data[`DDL_WORD_BITS-1:0];
          bit_d   = 5'h00;
          bclk_d  = 1'b0;
          state_d = DDL_SHIFT_LO;
        end
      end
      DDL_SHIFT_LO: begin
        if (tick) begin
          bclk_d  = 1'b1; // [RL5]
          state_d = DDL_SHIFT_HI;
        end
      end
      DDL_SHIFT_HI: begin
        if (tick) begin
          bclk_d = 1'b0;
          if (bit_q == LAST_BIT) begin
            latch_n_d = ~sel_q; // [RL7] [RL8] [RL9]
            state_d   = DDL_LATCH;
          end else begin
            bit_d   = 5'(bit_q + 5'h01);
            lsh_d   = {lsh_q[`DDL_WORD_BITS-2:0], 1'b0}; // [RL1]
            rsh_d   = {rsh_q[`DDL_WORD_BITS-2:0], 1'b0};
            state_d = DDL_SHIFT_LO;
          end
        end
      end
      DDL_LATCH: begin
        if (tick) begin
          latch_n_d = `DDL_LATCH_IDLE;
          state_d   = DDL_GAP;
        end
      end
      DDL_GAP: begin
        if (tick) begin
          state_d = DDL_IDLE;
        end
      end
      default: begin
        latch_n_d = `DDL_LATCH_IDLE;
        bclk_d    = 1'b0;
        state_d   = DDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_q   <= DDL_IDLE;
      div_q     <= 2'h0;
      bit_q     <= 5'h00;
      lsh_q     <= '0;
      rsh_q     <= '0;
      sel_q     <= 2'h0;
      bclk_q    <= 1'b0;
      latch_n_q <= `DDL_LATCH_IDLE;
    end else begin
      state_q   <= state_d;
      div_q     <= div_d;
      bit_q     <= bit_d;
      lsh_q     <= lsh_d;
      rsh_q     <= rsh_d;
      sel_q     <= sel_d;
      bclk_q    <= bclk_d;
      latch_n_q <= latch_n_d;
    end
  end

  assign O_BUSY               = (state_q != DDL_IDLE);
  assign LINK.bit_clk         = bclk_q; // [RL4]
  assign LINK.left_serial_in  = lsh_q[`DDL_LAST_BIT]; // [RL2]
  assign LINK.right_serial_in = rsh_q[`DDL_LAST_BIT];
  assign LINK.left_latch_n    = latch_n_q[0];
  assign LINK.right_latch_n   = latch_n_q[1];

endmodule

// File: dv/ddl_link_sva.sv
// Wire-level checks on the link between the word controller and the dual DAC input latch.
`timescale 1ns/1ns
module ddl_link_sva (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic bit_clk,
  input wire logic left_serial_in,
  input wire logic right_serial_in,
  input wire logic left_latch_n,
  input wire logic right_latch_n
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       bclk_q;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // Bit clock rises are counted modulo one word, so every latch must find the count at zero.
  always_comb begin
    cnt_d = cnt_q;
    if (bit_clk && !bclk_q) begin
      cnt_d = (cnt_q == 5'h11) ? 5'h00 : cnt_q + 5'h01;
    end
  end
  always_ff @(posedge I_CLK) begin
    bclk_q <= I_RESETN & bit_clk;
    cnt_q  <= I_RESETN ? cnt_d : 5'h00;
  end
  sequence s_low2(s); !s ##1 !s; endsequence
  property p_data_stable; bit_clk |-> $stable(left_serial_in) && $stable(right_serial_in); endproperty
  property p_bclk_high; $rose(bit_clk) |=> bit_clk ##1 !bit_clk; endproperty
  property p_bclk_low; $fell(bit_clk) |-> s_low2(bit_clk); endproperty
  property p_left_pulse; $fell(left_latch_n) |-> s_low2(left_latch_n) ##1 left_latch_n; endproperty
  property p_right_pulse; $fell(right_latch_n) |-> s_low2(right_latch_n) ##1 right_latch_n; endproperty
  property p_latch_quiet; !left_latch_n || !right_latch_n |-> !bit_clk; endproperty
  property p_word_done; $fell(left_latch_n) || $fell(right_latch_n) |-> cnt_q == 5'h00 && $fell(bit_clk); endproperty
  property p_gap; $rose(left_latch_n) || $rose(right_latch_n) |-> s_low2(bit_clk); endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while bit clock high");
  a_bclk_high: assert property (p_bclk_high) else $error("bit clock high phase wrong");
  a_bclk_low: assert property (p_bclk_low) else $error("bit clock low phase short");
  a_left_pulse: assert property (p_left_pulse) else $error("left latch pulse wrong");
  a_right_pulse: assert property (p_right_pulse) else $error("right latch pulse wrong");
  a_latch_quiet: assert property (p_latch_quiet) else $error("bit clock high during latch");
  a_word_done: assert property (p_word_done) else $error("latch before a whole word");
  a_gap: assert property (p_gap) else $error("no gap after latch");
endmodule

// File: dv/dual_dac_serial_input_latch_tb.sv
// Testbench joining controller and device ends over the serial link.
`timescale 1ns/1ns
`include "ddl_defs.svh"
module dual_dac_serial_input_latch_tb;
  import ddl_pkg::*;
  typedef struct packed {
    ddl_word_type l;
    ddl_word_type r;
    logic [1:0]   sel;
    ddl_word_type el;
    ddl_word_type er;
  } ddl_row_type;
  localparam ddl_row_type ROWS [5] = '{
    '{18'h2aaaa, 18'h15555, 2'h3, 18'h2aaaa, 18'h15555},
    '{18'h3ffff, 18'h00001, 2'h1, 18'h3ffff, 18'h15555},
    '{18'h20000, 18'h1ffff, 2'h2, 18'h3ffff, 18'h1ffff},
    '{18'h12345, 18'h0abcd, 2'h0, 18'h3ffff, 18'h1ffff},
    '{18'h00000, 18'h3ffff, 2'h3, 18'h00000, 18'h3ffff}};
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         valid = 1'b0;
  logic [1:0]   sel = 2'h0;
  ddl_word_type lw = 18'h0;
  ddl_word_type rw = 18'h0;
  logic         ready, busy, lupd, rupd, bclk_prev, ll_prev, lr_prev;
  ddl_word_type low, row, sh_l, sh_r, cap_l, cap_r;
  int           n_fail = 0, n_compared = 0, cycles = 0, n_lupd = 0, n_rupd = 0, n_acc;
  ddl_link_if ddl_link_if_inst ();
  ddl_ctl ddl_ctl_inst (.I_CLK(clk), .I_RESETN(resetn), .I_LEFT_WORD(lw), .I_RIGHT_WORD(rw), .I_LATCH_SEL(sel),
    .I_VALID(valid), .O_READY(ready), .O_BUSY(busy), .LINK(ddl_link_if_inst));
  ddl_dev ddl_dev_inst (.I_CLK(clk), .I_RESETN(resetn), .LINK(ddl_link_if_inst), .O_LEFT_WORD(low),
    .O_RIGHT_WORD(row), .O_LEFT_UPDATE(lupd), .O_RIGHT_UPDATE(rupd));
  ddl_link_sva ddl_link_sva_inst (.I_CLK(clk), .I_RESETN(resetn), .bit_clk(ddl_link_if_inst.bit_clk),
    .left_serial_in(ddl_link_if_inst.left_serial_in), .right_serial_in(ddl_link_if_inst.right_serial_in),
    .left_latch_n(ddl_link_if_inst.left_latch_n), .right_latch_n(ddl_link_if_inst.right_latch_n));
  always #10 clk = ~clk;
  // The bench shifts the wire on its own and keeps what each latch fall should have copied.
  always @(posedge clk) begin
    bclk_prev <= ddl_link_if_inst.bit_clk;
    ll_prev <= ddl_link_if_inst.left_latch_n;
    lr_prev <= ddl_link_if_inst.right_latch_n;
    if (ddl_link_if_inst.bit_clk === 1'b1 && bclk_prev === 1'b0) begin
      sh_l <= {sh_l[16:0], ddl_link_if_inst.left_serial_in};
      sh_r <= {sh_r[16:0], ddl_link_if_inst.right_serial_in};
    end
    if (ddl_link_if_inst.left_latch_n === 1'b0 && ll_prev === 1'b1) cap_l <= sh_l;
    if (ddl_link_if_inst.right_latch_n === 1'b0 && lr_prev === 1'b1) cap_r <= sh_r;
    if (lupd === 1'b1) n_lupd++;
    if (rupd === 1'b1) n_rupd++;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input ddl_word_type got, input ddl_word_type exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task push(input ddl_word_type l, input ddl_word_type r, input logic [1:0] s);
    @(posedge clk);
    lw <= l;
    rw <= r;
    sel <= s;
    valid <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
  endtask
  task wait_idle();
    int q;
    q = 0;
    while (q < 4) begin
      @(posedge clk);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(low, 18'h0);
    chk({16'h0, ready, busy}, 18'h2);
    for (int i = 0; i < 5; i++) begin
      push(ROWS[i].l, ROWS[i].r, ROWS[i].sel);
      wait_idle();
      chk(low, ROWS[i].el);
      chk(row, ROWS[i].er);
      if (ROWS[i].sel[0]) chk(cap_l, ROWS[i].el);
      if (ROWS[i].sel[1]) chk(cap_r, ROWS[i].er);
    end
    chk(18'(n_lupd), 18'h3);
    chk(18'(n_rupd), 18'h3);
    // Holding the request up fills the FIFO; refused words must never reach the converter.
    lw <= 18'h00abc;
    rw <= 18'h3f000;
    sel <= 2'h1;
    valid <= 1'b1;
    n_acc = 0;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      if (ready === 1'b1) n_acc++;
    end
    valid <= 1'b0;
    wait_idle();
    chk(18'(n_acc), 18'(`DDL_FIFO_DEPTH + 1));
    chk(18'(n_lupd), 18'(n_acc + 3));
    chk(cap_l, 18'h00abc);
    chk(low, 18'h00abc);
    chk(row, 18'h3ffff);
    // A reset in mid-word must drop the word in flight and leave the link idle.
    push(18'h0f0f0, 18'h30303, 2'h3);
    repeat (30) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(low, 18'h0);
    chk(row, 18'h0);
    chk({13'h0, ready, busy, ddl_link_if_inst.bit_clk, ddl_link_if_inst.left_latch_n,
      ddl_link_if_inst.right_latch_n}, 18'h13);
    push(18'h0f0f0, 18'h30303, 2'h3);
    wait_idle();
    chk(low, 18'h0f0f0);
    chk(row, 18'h30303);
    finish_test();
  end
endmodule
